// file: hw/cap_sense_pkg.sv
// constants of the capacitance-to-digital sense unit
// assumes an 8-bit register port on the system clock, one register per index
//
// Operation
// (R1) unit works only while unit_enable is 1
// (R2) start_mode_sel picks one of eight starts
// (R3) writing busy 1 starts one conversion
// (R4) continuous modes wait for busy, then repeat; continuous scan with multi_channel_en set clears busy after one result
// (R5) conversion done flag raises enabled irq
// (R6) single scan converts all masked channels; code runs from channel_mux_sel up to the highest masked one
// (R7) length 12/13/14/16 bits, 13 after reset
// (R8) unconverted low result bits read zero
// (R9) done only after last accumulated sample
// (R10) multi_channel_en shorts masked channels together
// (R11) gain 1x to 8x, reset 8x
// (R12) greater-than compare can wake from suspend
// (R13) alt method wakes on scan/conversion end
// (R14) wake only after all samples accumulated
// (R15) wake_on_irq_cfg selects extra wake events
// (R16) software disables unit before sleep
// (R17) software enables, sets mode, then configures
// (R18) software sets measured pins analog
// (R19) irq when result crosses 16-bit threshold
// (R20) flag 1 above threshold, else 0
// (R21) accumulate 1..64 samples, divide, store
// (R22) compare hit stops scan until busy write
// (R23) busy reads 1 while conversion runs
`default_nettype none
package cap_sense_pkg;
  // ****************************************************************
  // register indices
  // ****************************************************************
  localparam logic [3:0] SENSE_CONTROL_REG  = 4'h0;
  localparam logic [3:0] SENSE_CONFIG_REG   = 4'h1;
  localparam logic [3:0] SENSE_MODE_REG_A   = 4'h2;
  localparam logic [3:0] SENSE_MODE_REG_B   = 4'h3;
  localparam logic [3:0] SENSE_MODE_REG_C   = 4'h4;
  localparam logic [3:0] SCAN_MASK_LOW      = 4'h5;
  localparam logic [3:0] SCAN_MASK_HIGH     = 4'h6;
  localparam logic [3:0] THRESHOLD_HIGH     = 4'h7;
  localparam logic [3:0] THRESHOLD_LOW      = 4'h8;
  localparam logic [3:0] RESULT_HIGH        = 4'h9;
  localparam logic [3:0] RESULT_LOW         = 4'ha;
  localparam logic [3:0] CHANNEL_MUX_SEL    = 4'hb;
  localparam logic [3:0] EXT_IRQ_ENABLE_REG = 4'hc;
  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int CTL_ENABLE   = 7;
  localparam int CTL_DONE     = 5;
  localparam int CTL_BUSY     = 4;
  localparam int CTL_EOS      = 3;
  localparam int CTL_GT       = 2;
  localparam int CTL_CMP      = 0;
  localparam int CFG_MODE_LSB = 4;
  localparam int CFG_ACC_LSB  = 0;
  localparam int MDA_ALT_SCAN = 7;
  localparam int MDA_GAIN_LSB = 0;
  localparam int MDB_WOI      = 6;
  localparam int MDC_MCEN     = 7;
  localparam int MDC_LEN_LSB  = 0;
  localparam int IEN_DONE     = 0;
  localparam int IEN_EOS      = 1;
  localparam int IEN_GT       = 5;
  // ****************************************************************
  // reset values and encodings
  // ****************************************************************
  localparam logic [2:0] GAIN_RESET = 3'h7;   // 8x
  localparam logic [1:0] LEN_RESET  = 2'h1;   // 13 bits
  localparam logic [1:0] LEN_12     = 2'h0;
  localparam logic [1:0] LEN_13     = 2'h1;
  localparam logic [1:0] LEN_14     = 2'h2;
  localparam logic [3:0] LSB_12     = 4'h4;
  localparam logic [3:0] LSB_13     = 4'h3;
  localparam logic [3:0] LSB_14     = 4'h2;
  localparam logic [3:0] LSB_16     = 4'h0;
  localparam int ACC_W = 22;
  typedef enum logic [2:0] {
    MODE_SW     = 3'b000,
    MODE_T0     = 3'b001,
    MODE_T2     = 3'b010,
    MODE_T1     = 3'b011,
    MODE_T3     = 3'b100,
    MODE_SCAN1  = 3'b101,
    MODE_CONT   = 3'b110,
    MODE_CSCAN  = 3'b111
  } start_mode_t;
endpackage : cap_sense_pkg
`default_nettype wire

// file: hw/sar_engine.sv
// successive approximation sequencer for one capacitance conversion
// assumes cmp_above is already synchronised to mclk
`default_nettype none
module sar_engine
  import cap_sense_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        rstn,
  input  wire logic        start,
  input  wire logic        abort,
  input  wire logic [1:0]  len_sel,
  input  wire logic        cmp_above,
  output logic             busy,
  output logic             done,
  output logic [15:0]      result,
  output logic [15:0]      dac_code
);
  // ****************************************************************
  // state
  // ****************************************************************
  typedef enum logic [1:0] {
    E_IDLE   = 2'b00,
    E_DRIVE  = 2'b01,
    E_SETTLE = 2'b11,
    E_SAMPLE = 2'b10
  } eng_state_t;

  typedef struct packed {
    eng_state_t  st;
    logic [3:0]  idx;
    logic [15:0] code;
    logic [15:0] res;
    logic        done;
  } eng_t;

  eng_t q_reg;
  eng_t q_next;

  // lowest converted bit for each length
  function automatic logic [3:0] lsb_index(input logic [1:0] len);
    case (len)
      LEN_12:  lsb_index = LSB_12;
      LEN_13:  lsb_index = LSB_13;
      LEN_14:  lsb_index = LSB_14;
      default: lsb_index = LSB_16;
    endcase
  endfunction : lsb_index

  // ****************************************************************
  // next state: one bit per drive/settle/sample step, msb first
  // ****************************************************************
  always_comb
  begin
    q_next      = q_reg;
    q_next.done = 1'b0;
    case (q_reg.st)
      E_IDLE:
      begin
        if (start && !abort)
        begin
          q_next.st   = E_DRIVE;
          q_next.idx  = 4'hf;
          q_next.code = 16'h8000;
        end
      end
      // two cycles cover the comparator's two-stage synchroniser
      E_DRIVE:
        q_next.st = E_SETTLE;   // trial code reaches the pin
      E_SETTLE:
        q_next.st = E_SAMPLE;   // synchroniser now shows this trial
      E_SAMPLE:
      begin
        // (R7) bit decision
        if (!cmp_above)
          q_next.code[q_reg.idx] = 1'b0;
        if (q_reg.idx == lsb_index(len_sel))
        begin
          q_next.st   = E_IDLE;
          q_next.done = 1'b1;
          // (R8) low bits zero
          q_next.res  = cmp_above ? q_reg.code : (q_reg.code & ~(16'h0001 << q_reg.idx));
        end
        else
        begin
          q_next.idx                    = q_reg.idx - 4'h1;
          q_next.code[q_reg.idx - 4'h1] = 1'b1;
          q_next.st                     = E_DRIVE;
        end
      end
      default:
        q_next.st = E_IDLE;
    endcase
    if (abort)
    begin
      q_next.st   = E_IDLE;
      q_next.done = 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      q_reg <= '{st: E_IDLE, idx: 4'h0, code: 16'h0000, res: 16'h0000, done: 1'b0};
    else
      q_reg <= q_next;
  end

  assign busy     = (q_reg.st != E_IDLE);
  assign done     = q_reg.done;
  assign result   = q_reg.res;
  assign dac_code = q_reg.code;
endmodule : sar_engine
`default_nettype wire

// file: hw/cap_sense_unit.sv
// control, registers, accumulator and compare of the sense unit
// assumes an 8-bit register port on mclk and an analog comparator pin
`default_nettype none
module cap_sense_unit
  import cap_sense_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        rstn,
  input  wire logic [3:0]  addr,
  input  wire logic [7:0]  wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic      [7:0]  rdata,
  input  wire logic [3:0]  timer_ovf,
  input  wire logic        cmp_pin,
  output logic             sense_power_on,
  output logic      [15:0] channel_connect,
  output logic      [2:0]  gain_sel,
  output logic      [15:0] dac_code,
  output logic             conv_done_irq,
  output logic             end_scan_irq,
  output logic             threshold_irq,
  output logic             wake_req
);
  // ****************************************************************
  // state
  // ****************************************************************
  typedef enum logic [0:0] {
    T_IDLE = 1'b0,
    T_CONV = 1'b1
  } ctl_state_t;

  typedef struct packed {
    ctl_state_t       st;
    logic [1:0]       sync;
    logic             unit_enable;
    logic             conv_busy;
    logic             done_flag;
    logic             eos_flag;
    logic             gt_flag;
    logic             threshold_cmp_flag;
    start_mode_t      start_mode_sel;
    logic [2:0]       accum_count_sel;
    logic             alt_scan_method_en;
    logic [2:0]       gain;
    logic             wake_on_irq_cfg;
    logic             multi_channel_en;
    logic [1:0]       conv_length_sel;
    logic [15:0]      scan_mask;
    logic [15:0]      threshold;
    logic [15:0]      result;
    logic [3:0]       channel_mux_sel;
    logic [7:0]       irq_en;
    logic [ACC_W-1:0] acc;
    logic [6:0]       samples;
    logic             start;
    logic             wake;
    logic [7:0]       rdata;
  } ctl_t;

  ctl_t q_reg;
  ctl_t q_next;

  logic        eng_busy;
  logic        eng_done;
  logic [15:0] eng_result;

  // samples per accumulated result
  function automatic logic [6:0] acc_count(input logic [2:0] sel);
    case (sel)
      3'h1:    acc_count = 7'h04;
      3'h2:    acc_count = 7'h08;
      3'h3:    acc_count = 7'h10;
      3'h4:    acc_count = 7'h20;
      3'h5:    acc_count = 7'h40;
      default: acc_count = 7'h01;
    endcase
  endfunction : acc_count

  // shift that divides by the sample count
  function automatic logic [2:0] acc_shift(input logic [2:0] sel);
    case (sel)
      3'h1:    acc_shift = 3'h2;
      3'h2:    acc_shift = 3'h3;
      3'h3:    acc_shift = 3'h4;
      3'h4:    acc_shift = 3'h5;
      3'h5:    acc_shift = 3'h6;
      default: acc_shift = 3'h0;
    endcase
  endfunction : acc_shift

  // next masked channel above cur; wrap set when none is left
  function automatic logic [4:0] next_chan(input logic [15:0] mask, input logic [3:0] cur);
    logic [4:0] r;
    logic       found;
    r     = {1'b1, cur};
    found = 1'b0;
    for (int i = 15; i >= 0; i--)
      if (mask[i] && (i > int'(cur)))
        r = {1'b0, 4'(i)};
    for (int i = 15; i >= 0; i--)
      if (mask[i])
        found = 1'b1;
    if (r[4] && found)
      for (int i = 15; i >= 0; i--)
        if (mask[i])
          r = {1'b1, 4'(i)};
    return r;
  endfunction : next_chan

  // ****************************************************************
  // conversion engine
  // ****************************************************************
  sar_engine u_sar (
    .mclk      (mclk),
    .rstn      (rstn),
    .start     (q_reg.start),
    .abort     (!q_reg.unit_enable),
    .len_sel   (q_reg.conv_length_sel),
    .cmp_above (q_reg.sync[1]),
    .busy      (eng_busy),
    .done      (eng_done),
    .result    (eng_result),
    .dac_code  (dac_code)
  );

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb
  begin
    logic [ACC_W-1:0] sum;
    logic [ACC_W-1:0] avg;
    logic [4:0]       nc;
    logic             above;
    logic             timer_hit;
    logic             is_scan;
    sum       = '0;
    avg       = '0;
    nc        = 5'h00;
    above     = 1'b0;
    timer_hit = 1'b0;
    is_scan   = 1'b0;
    q_next       = q_reg;
    q_next.start = 1'b0;
    q_next.wake  = 1'b0;
    q_next.sync  = {q_reg.sync[0], cmp_pin};
    is_scan      = (q_reg.start_mode_sel == MODE_SCAN1) || (q_reg.start_mode_sel == MODE_CSCAN);
    is_scan      = is_scan && !q_reg.multi_channel_en;
    // (R2) timer sources
    case (q_reg.start_mode_sel)
      MODE_T0: timer_hit = timer_ovf[0];
      MODE_T1: timer_hit = timer_ovf[1];
      MODE_T2: timer_hit = timer_ovf[2];
      MODE_T3: timer_hit = timer_ovf[3];
      default: timer_hit = 1'b0;
    endcase

    // register reads, data stand one cycle later
    q_next.rdata = 8'h00;
    if (rd)
    begin
      case (addr)
        SENSE_CONTROL_REG:
          q_next.rdata = {q_reg.unit_enable, 1'b0, q_reg.done_flag, q_reg.conv_busy,
                          q_reg.eos_flag, q_reg.gt_flag, 1'b0, q_reg.threshold_cmp_flag};
        SENSE_CONFIG_REG:   q_next.rdata = {1'b0, q_reg.start_mode_sel, 1'b0, q_reg.accum_count_sel};
        SENSE_MODE_REG_A:   q_next.rdata = {q_reg.alt_scan_method_en, 4'h0, q_reg.gain};
        SENSE_MODE_REG_B:   q_next.rdata = {1'b0, q_reg.wake_on_irq_cfg, 6'h00};
        SENSE_MODE_REG_C:   q_next.rdata = {q_reg.multi_channel_en, 5'h00, q_reg.conv_length_sel};
        SCAN_MASK_LOW:      q_next.rdata = q_reg.scan_mask[7:0];
        SCAN_MASK_HIGH:     q_next.rdata = q_reg.scan_mask[15:8];
        THRESHOLD_HIGH:     q_next.rdata = q_reg.threshold[15:8];
        THRESHOLD_LOW:      q_next.rdata = q_reg.threshold[7:0];
        RESULT_HIGH:        q_next.rdata = q_reg.result[15:8];
        RESULT_LOW:         q_next.rdata = q_reg.result[7:0];
        CHANNEL_MUX_SEL:    q_next.rdata = {4'h0, q_reg.channel_mux_sel};
        EXT_IRQ_ENABLE_REG: q_next.rdata = q_reg.irq_en;
        default:            q_next.rdata = 8'h00;
      endcase
    end

    // register writes; done, eos and gt flags clear on a written 0
    if (wr)
    begin
      case (addr)
        SENSE_CONTROL_REG:
        begin
          q_next.unit_enable = wdata[CTL_ENABLE];
          // (R3) software start
          if (wdata[CTL_BUSY])
            q_next.conv_busy = 1'b1;
          if (!wdata[CTL_DONE])
            q_next.done_flag = 1'b0;
          if (!wdata[CTL_EOS])
            q_next.eos_flag = 1'b0;
          if (!wdata[CTL_GT])
            q_next.gt_flag = 1'b0;
        end
        SENSE_CONFIG_REG:
        begin
          q_next.start_mode_sel  = start_mode_t'(wdata[CFG_MODE_LSB +: 3]);
          q_next.accum_count_sel = wdata[CFG_ACC_LSB +: 3];
        end
        SENSE_MODE_REG_A:
        begin
          q_next.alt_scan_method_en = wdata[MDA_ALT_SCAN];
          // (R11) gain select
          q_next.gain               = wdata[MDA_GAIN_LSB +: 3];
        end
        SENSE_MODE_REG_B:   q_next.wake_on_irq_cfg = wdata[MDB_WOI];
        SENSE_MODE_REG_C:
        begin
          q_next.multi_channel_en = wdata[MDC_MCEN];
          q_next.conv_length_sel  = wdata[MDC_LEN_LSB +: 2];
        end
        SCAN_MASK_LOW:      q_next.scan_mask[7:0]  = wdata;
        SCAN_MASK_HIGH:     q_next.scan_mask[15:8] = wdata;
        THRESHOLD_HIGH:     q_next.threshold[15:8] = wdata;
        THRESHOLD_LOW:      q_next.threshold[7:0]  = wdata;
        CHANNEL_MUX_SEL:    q_next.channel_mux_sel = wdata[3:0];
        EXT_IRQ_ENABLE_REG: q_next.irq_en          = wdata;
        default:            q_next.irq_en          = q_reg.irq_en;
      endcase
    end

    // conversion sequencing
    case (q_reg.st)
      T_IDLE:
      begin
        // (R4) busy arms the start
        if (q_reg.unit_enable && (q_reg.conv_busy || timer_hit))
        begin
          q_next.st        = T_CONV;
          q_next.start     = 1'b1;
          q_next.conv_busy = 1'b1;
          q_next.acc       = '0;
          q_next.samples   = 7'h00;
        end
      end
      T_CONV:
      begin
        if (eng_done)
        begin
          // (R21) accumulate samples
          sum            = q_reg.acc + ACC_W'(eng_result);
          q_next.acc     = sum;
          q_next.samples = q_reg.samples + 7'h01;
          if ((q_reg.samples + 7'h01) != acc_count(q_reg.accum_count_sel))
            q_next.start = 1'b1;
          else
          begin
            // (R9) last sample done
            avg                       = sum >> acc_shift(q_reg.accum_count_sel);
            q_next.result             = avg[15:0];
            q_next.acc                = '0;
            q_next.samples            = 7'h00;
            // (R20) threshold compare
            above                     = (avg[15:0] > q_reg.threshold);
            q_next.threshold_cmp_flag = above;
            // (R5) completion flag
            q_next.done_flag          = 1'b1;
            // (R19) crossing event
            if (above)
              q_next.gt_flag = 1'b1;
            // (R12) wake on touch
            q_next.wake = above;
            // (R13) (R14) (R15) wake per conversion
            if (q_reg.alt_scan_method_en && q_reg.wake_on_irq_cfg &&
                (q_reg.start_mode_sel == MODE_CONT || q_reg.start_mode_sel == MODE_CSCAN))
              q_next.wake = 1'b1;
            nc = next_chan(q_reg.scan_mask, q_reg.channel_mux_sel);
            q_next.st = T_IDLE;
            if (q_reg.start_mode_sel == MODE_CONT)
              q_next.conv_busy = 1'b1;
            else if (is_scan)
            begin
              // (R22) hit stops scan
              if (above)
                q_next.conv_busy = 1'b0;
              else
              begin
                // (R6) step through mask
                q_next.channel_mux_sel = nc[3:0];
                if (nc[4])
                begin
                  q_next.eos_flag = 1'b1;
                  if (q_reg.start_mode_sel == MODE_SCAN1)
                  begin
                    q_next.conv_busy = 1'b0;
                    // (R13) wake at scan end
                    if (q_reg.alt_scan_method_en && q_reg.wake_on_irq_cfg)
                      q_next.wake = 1'b1;
                  end
                end
              end
            end
            else
              // (R23) busy drops at end
              q_next.conv_busy = 1'b0;
          end
        end
      end
      default:
        q_next.st = T_IDLE;
    endcase

    // (R1) shutdown returns to idle and cancels start and busy, unless the same write sets both enable and busy
    if (!q_reg.unit_enable)
    begin
      q_next.st        = T_IDLE;
      q_next.start     = 1'b0;
      q_next.conv_busy = wr && (addr == SENSE_CONTROL_REG) &&
                         wdata[CTL_ENABLE] && wdata[CTL_BUSY];
    end
  end

  // ****************************************************************
  // registers
  // ****************************************************************
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      q_reg                 <= '0;
      q_reg.st              <= T_IDLE;
      q_reg.start_mode_sel  <= MODE_SW;
      q_reg.gain            <= GAIN_RESET;
      q_reg.conv_length_sel <= LEN_RESET;
    end
    else
      q_reg <= q_next;
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign rdata          = q_reg.rdata;
  assign sense_power_on = q_reg.unit_enable;
  assign gain_sel       = q_reg.gain;
  assign wake_req       = q_reg.wake;
  // (R10) shorted channels
  assign channel_connect = !q_reg.unit_enable ? 16'h0000 :
                           q_reg.multi_channel_en ? q_reg.scan_mask :
                           (16'h0001 << q_reg.channel_mux_sel);
  // (R5) enabled interrupt lines
  assign conv_done_irq = q_reg.done_flag & q_reg.irq_en[IEN_DONE];
  assign end_scan_irq  = q_reg.eos_flag & q_reg.irq_en[IEN_EOS];
  assign threshold_irq = q_reg.gt_flag & q_reg.irq_en[IEN_GT];
endmodule : cap_sense_unit
`default_nettype wire

// file: verif/cap_sense_checker.sv
// port checks of the sense unit
// assumes a bind onto cap_sense_unit
`default_nettype none
module cap_sense_checker
  import cap_sense_pkg::*;
(
  input wire logic        mclk,
  input wire logic        rstn,
  input wire logic [3:0]  addr,
  input wire logic [7:0]  wdata,
  input wire logic        wr,
  input wire logic        rd,
  input wire logic [7:0]  rdata,
  input wire logic        sense_power_on,
  input wire logic [15:0] channel_connect,
  input wire logic [2:0]  gain_sel,
  input wire logic        conv_done_irq,
  input wire logic        end_scan_irq,
  input wire logic        threshold_irq,
  input wire logic        wake_req
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);
  logic [7:0] wd_q;
  // write data of the last cycle
  always_ff @(posedge mclk) wd_q <= wdata;
  // ***
  // assertions
  // ***
  enable_follows_a: assert property (
    wr && addr == SENSE_CONTROL_REG |=> sense_power_on == wd_q[CTL_ENABLE])
    else $error("power state differs from enable write");
  off_open_a: assert property (
    !sense_power_on |-> channel_connect == 16'h0000) else $error("electrodes on while off");
  gain_write_a: assert property (
    wr && addr == SENSE_MODE_REG_A |=> gain_sel == wd_q[2:0]) else $error("gain mismatch");
  reset_gain_a: assert property (
    $rose(rstn) |-> gain_sel == GAIN_RESET && !sense_power_on) else $error("bad reset");
  done_mask_a: assert property (
    wr && addr == EXT_IRQ_ENABLE_REG && !wdata[IEN_DONE] |=> !conv_done_irq)
    else $error("done irq while masked");
  scan_mask_a: assert property (
    wr && addr == EXT_IRQ_ENABLE_REG && !wdata[IEN_EOS] |=> !end_scan_irq)
    else $error("scan irq while masked");
  gt_mask_a: assert property (
    wr && addr == EXT_IRQ_ENABLE_REG && !wdata[IEN_GT] |=> !threshold_irq)
    else $error("threshold irq while masked");
  wake_pulse_a: assert property (
    wake_req |=> !wake_req) else $error("wake longer than one cycle");
  read_idle_a: assert property (
    !rd |=> rdata == 8'h00) else $error("read data outside read slot");
  cover property (conv_done_irq);
  cover property (end_scan_irq);
  cover property (wake_req);
endmodule : cap_sense_checker
bind cap_sense_unit cap_sense_checker chk (.mclk(mclk), .rstn(rstn), .addr(addr),
  .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .sense_power_on(sense_power_on),
  .channel_connect(channel_connect), .gain_sel(gain_sel), .conv_done_irq(conv_done_irq),
  .end_scan_irq(end_scan_irq), .threshold_irq(threshold_irq), .wake_req(wake_req));
`default_nettype wire

// file: verif/electrode_model.sv
// electrode node seen by the sense comparator
// assumes trial code and power state from the unit
`default_nettype none
module electrode_model
#(
  parameter logic [15:0] NODE_CODE = 16'h5a5f
)
(
  input  wire logic        mclk,
  input  wire logic        power_on,
  input  wire logic [15:0] dac_code,
  output logic             cmp_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  logic idle_q = 1'b0;
  // comparator output is meaningless while powered down
  always_ff @(posedge mclk) idle_q <= ~idle_q;
  assign cmp_pin = power_on ? (NODE_CODE > dac_code) : idle_q;
endmodule : electrode_model
`default_nettype wire

// file: verif/cap_sense_unit_tb_top.sv
// register level bench of the sense unit
// assumes electrode model and bound checker
`default_nettype none
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin n_errors++; \
  $display("[ERR] %0t got %h exp %h", $time, (g), (e)); end end
module cap_sense_unit_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import cap_sense_pkg::*;
  localparam logic [15:0] NODE = 16'h5a5f;
  logic        mclk = 1'b0;
  logic        rstn = 1'b0;
  logic [3:0]  addr = 4'h0;
  logic [7:0]  wdata = 8'h00;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic [3:0]  timer_ovf = 4'h0;
  logic [7:0]  rdata, d;
  logic        cmp_pin, sense_power_on, conv_done_irq, end_scan_irq, threshold_irq, wake_req;
  logic [15:0] channel_connect, dac_code;
  logic [2:0]  gain_sel;
  logic [3:0]  lsbs [3] = '{LSB_12, LSB_13, LSB_14};
  int          tbit [5] = '{0, 0, 2, 1, 3};
  int          n_errors = 0, num_checks = 0, n_wake = 0, w0;
  cap_sense_unit dut (.mclk(mclk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .timer_ovf(timer_ovf), .cmp_pin(cmp_pin),
    .sense_power_on(sense_power_on), .channel_connect(channel_connect),
    .gain_sel(gain_sel), .dac_code(dac_code), .conv_done_irq(conv_done_irq),
    .end_scan_irq(end_scan_irq), .threshold_irq(threshold_irq), .wake_req(wake_req));
  electrode_model #(.NODE_CODE(NODE)) pad (.mclk(mclk), .power_on(sense_power_on),
    .dac_code(dac_code), .cmp_pin(cmp_pin));
  // ***
  // bus tasks
  // ***
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] v);
    @(posedge mclk);
    addr  <= a;
    wdata <= v;
    wr    <= 1'b1;
    @(posedge mclk);
    wr    <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [3:0] a);
    @(posedge mclk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge mclk);
    rd   <= 1'b0;
    #1 d = rdata;
  endtask : rd_reg
  task automatic wait_idle();
    for (int i = 0; i < 400; i++)
    begin
      rd_reg(SENSE_CONTROL_REG);
      if (d[CTL_BUSY] === 1'b0) return;
    end
    n_errors++;
    $display("[ERR] %0t busy stuck", $time);
  endtask : wait_idle
  task automatic chk_result(input logic [15:0] e);
    logic [7:0] h;
    rd_reg(RESULT_HIGH);
    h = d;
    rd_reg(RESULT_LOW);
    `CHK({h, d}, e)
  endtask : chk_result
  task automatic pulse(input int b);
    @(posedge mclk);
    timer_ovf <= 4'(1 << b);
    @(posedge mclk);
    timer_ovf <= 4'h0;
  endtask : pulse
  task automatic conclude();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : conclude
  // clock, wake counter and watchdog
  initial forever #20 mclk = ~mclk;
  always @(posedge mclk) if (wake_req === 1'b1) n_wake++;
  initial
  begin
    repeat (20000) @(posedge mclk);
    n_errors++;
    conclude();
  end
  // ***
  // tests
  // ***
  initial
  begin
    repeat (2) @(posedge mclk);
    rstn <= 1'b1;
    `CHK(gain_sel, GAIN_RESET)
    rd_reg(SENSE_MODE_REG_C);
    `CHK(d[1:0], LEN_RESET)
    rd_reg(4'hd);
    `CHK(d, 8'h00)
    wr_reg(SENSE_CONTROL_REG, 8'h10);
    repeat (40) @(posedge mclk);
    rd_reg(SENSE_CONTROL_REG);
    `CHK(d[CTL_BUSY], 1'b0)
    wr_reg(SENSE_CONTROL_REG, 8'h80);
    wr_reg(SENSE_CONFIG_REG, 8'h00);
    wr_reg(EXT_IRQ_ENABLE_REG, 8'h23);
    wr_reg(THRESHOLD_HIGH, 8'hff);
    wr_reg(THRESHOLD_LOW, 8'hff);
    for (int k = 0; k < 3; k++)
    begin
      wr_reg(SENSE_MODE_REG_C, 8'(k));
      wr_reg(SENSE_CONTROL_REG, 8'h90);
      rd_reg(SENSE_CONTROL_REG);
      `CHK(d[CTL_BUSY], 1'b1)
      wait_idle();
      `CHK(conv_done_irq, 1'b1)
      chk_result(NODE & (16'hffff << lsbs[k]));
    end
    wr_reg(SENSE_MODE_REG_C, 8'h01);
    for (int m = 1; m < 5; m++)
    begin
      wr_reg(SENSE_CONFIG_REG, 8'(m << 4));
      pulse(tbit[m] ^ 1);
      rd_reg(SENSE_CONTROL_REG);
      `CHK(d[CTL_BUSY], 1'b0)
      pulse(tbit[m]);
      rd_reg(SENSE_CONTROL_REG);
      `CHK(d[CTL_BUSY], 1'b1)
      wait_idle();
    end
    wr_reg(SENSE_CONFIG_REG, 8'h00);
    wr_reg(THRESHOLD_HIGH, 8'h10);
    w0 = n_wake;
    wr_reg(SENSE_CONTROL_REG, 8'h90);
    wait_idle();
    `CHK(d[CTL_CMP], 1'b1)
    `CHK(threshold_irq, 1'b1)
    `CHK(n_wake, w0 + 1)
    wr_reg(THRESHOLD_HIGH, 8'hff);
    wr_reg(SENSE_CONFIG_REG, 8'h01);
    wr_reg(SENSE_CONTROL_REG, 8'h90);
    repeat (60) @(posedge mclk);
    rd_reg(SENSE_CONTROL_REG);
    `CHK(d[CTL_DONE], 1'b0)
    wait_idle();
    `CHK(d[CTL_CMP], 1'b0)
    chk_result(NODE & (16'hffff << LSB_13));
    wr_reg(SENSE_CONFIG_REG, 8'h50);
    wr_reg(SENSE_MODE_REG_A, 8'h87);
    wr_reg(SENSE_MODE_REG_B, 8'h40);
    wr_reg(SCAN_MASK_LOW, 8'h03);
    wr_reg(CHANNEL_MUX_SEL, 8'h00);
    w0 = n_wake;
    wr_reg(SENSE_CONTROL_REG, 8'h90);
    wait_idle();
    `CHK(end_scan_irq, 1'b1)
    `CHK(n_wake, w0 + 1)
    wr_reg(SENSE_MODE_REG_C, 8'h81);
    wr_reg(SCAN_MASK_HIGH, 8'h01);
    wr_reg(SCAN_MASK_LOW, 8'ha0);
    repeat (2) @(posedge mclk);
    `CHK(channel_connect, 16'h01a0)
    wr_reg(SENSE_MODE_REG_C, 8'h01);
    wr_reg(SENSE_CONTROL_REG, 8'h80);
    wr_reg(SENSE_CONFIG_REG, 8'h60);
    repeat (100) @(posedge mclk);
    rd_reg(SENSE_CONTROL_REG);
    `CHK(d[CTL_DONE], 1'b0)
    wr_reg(SENSE_CONTROL_REG, 8'h90);
    repeat (200) @(posedge mclk);
    rd_reg(SENSE_CONTROL_REG);
    `CHK(d[CTL_DONE], 1'b1)
    `CHK(d[CTL_BUSY], 1'b1)
    wr_reg(SENSE_CONTROL_REG, 8'h00);
    rd_reg(SENSE_CONTROL_REG);
    `CHK(d[CTL_BUSY], 1'b0)
    `CHK(channel_connect, 16'h0000)
    // continuous scan: first hit stops the scan, mux held
    wr_reg(SENSE_CONFIG_REG, 8'h70);
    wr_reg(THRESHOLD_HIGH, 8'h10);
    wr_reg(CHANNEL_MUX_SEL, 8'h05);
    wr_reg(SENSE_CONTROL_REG, 8'h90);
    wait_idle();
    `CHK(d[CTL_GT], 1'b1)
    rd_reg(CHANNEL_MUX_SEL);
    `CHK(d, 8'h05)
    conclude();
  end
endmodule : cap_sense_unit_tb_top
`default_nettype wire
